// File: hw/delta_outputs.sv
// Delta angle (y, z) and delta velocity (x, y) integration and readout.
// Assumes calibrated gyro and accel samples arrive on i_sys_clk with a
// valid strobe at the sample rate, and a register read port driven by
// the serial interface decoder on the same clock.
//
// How it works
// - Velocity delta: sum of consecutive sample pairs, scaled
// - Window length is decimation setting plus one
// - Nominal 2000 SPS used in scaling
// - Each axis accumulated separately between updates
// - Angle high word: signed, upper sixteen bits
// - Angle low word: lower sixteen result bits
// - High and low words form one value
// - Velocity high word: signed, 400 m/sec range
// - Velocity low word: lower sixteen result bits
// - Sixteen-bit high words saturate at 7fff/8000
// - Thirty-two-bit result saturates at full range
// - Y angle words read-only at 0x28/0x2a
// - Z angle words read-only at 0x2c/0x2e
// - X velocity words read-only at 0x30/0x32
// - Y velocity words read-only at 0x34/0x36
// - Angle uses the same trapezoidal integration
// - Angle range depends on gyro model variant

`timescale 1ns/1ps
`default_nettype none

module delta_outputs #(
  parameter int SAMPLE_RATE_SPS = delta_pkg::NOMINAL_RATE_SPS
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_rstn,
  // Calibrated sensor samples
  input  wire logic                              i_smp_valid,
  output logic                                   o_smp_ready,
  input  wire logic signed [delta_pkg::SAMPLE_W-1:0] i_gyro_y,
  input  wire logic signed [delta_pkg::SAMPLE_W-1:0] i_gyro_z,
  input  wire logic signed [delta_pkg::SAMPLE_W-1:0] i_accl_x,
  input  wire logic signed [delta_pkg::SAMPLE_W-1:0] i_accl_y,
  // Decimation control from the configuration logic
  input  wire logic        [delta_pkg::DEC_W-1:0]    i_decimation_setting,
  // Register read port
  input  wire logic                              i_reg_rd,
  input  wire logic        [delta_pkg::ADDR_W-1:0]   i_reg_addr,
  output logic             [delta_pkg::WORD_W-1:0]   o_reg_rdata,
  output logic                                   o_reg_rvalid,
  // One-cycle pulse when a new set of deltas is loaded
  output logic                                   o_sample_available
);

  import delta_pkg::*;

  // ****************************************************************
  // Scaling constants
  // ****************************************************************
  // Reciprocal of twice the sample rate, in units of 2^-RECIP_SHIFT
  localparam logic [RECIP_W-1:0] RECIP =
    RECIP_W'(((64'd1 << RECIP_SHIFT) + 64'(SAMPLE_RATE_SPS)) / (64'd2 * 64'(SAMPLE_RATE_SPS)));
  localparam int PROD_W = ACC_W + RECIP_W + 1;
  localparam int BUF_W  = NUM_AXES * SAMPLE_W;
  localparam int BUF_DEPTH = 2; // Covers the one-cycle scaling stall

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [BUF_W-1:0]                 buf_wr_data;
  logic [BUF_W-1:0]                 buf_rd_data;
  logic                             buf_rd_valid;
  logic                             buf_rd_ready;
  logic                             take;
  win_state_e                       state_q;
  win_state_e                       state_d;
  logic [DEC_W:0]                   win_cnt_q;
  logic [DEC_W:0]                   win_last;
  logic                             win_end;
  logic signed [SAMPLE_W-1:0]       prev_q   [NUM_AXES];
  logic signed [ACC_W-1:0]          acc_q    [NUM_AXES];
  logic signed [PROD_W-1:0]         prod     [NUM_AXES];
  logic signed [PROD_W-1:0]         scaled   [NUM_AXES];
  logic [DELTA_W-1:0]               sat      [NUM_AXES];
  logic [DELTA_W-1:0]               delta_q  [NUM_AXES];
  logic                             avail_q;
  logic [WORD_W-1:0]                rdata_q;
  logic                             rvalid_q;

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  // Packed channel order follows the CH_* constants
  assign buf_wr_data = {i_accl_y, i_accl_x, i_gyro_z, i_gyro_y};

  // Absorbs samples that arrive while the window is being scaled
  sample_buffer #(
    .WIDTH (BUF_W),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .i_sys_clk  (i_sys_clk),
    .i_rstn     (i_rstn),
    .i_wr_valid (i_smp_valid),
    .o_wr_ready (o_smp_ready),
    .i_wr_data  (buf_wr_data),
    .o_rd_valid (buf_rd_valid),
    .i_rd_ready (buf_rd_ready),
    .o_rd_data  (buf_rd_data)
  );

  // Drain stalls for the one scaling cycle at each window end
  assign buf_rd_ready = (state_q == ST_ACCUM);
  assign take         = buf_rd_valid && buf_rd_ready;

  // ****************************************************************
  // Window control
  // ****************************************************************
  // Window spans setting + 1 pre-decimation samples
  assign win_last = {1'b0, i_decimation_setting};
  assign win_end  = take && (win_cnt_q >= win_last);

  // Next state of the window sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ACCUM: begin
        if (win_end) begin
          state_d = ST_SCALE;
        end
      end
      ST_SCALE: begin
        state_d = ST_ACCUM;
      end
      default: begin
        state_d = ST_ACCUM;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_ACCUM;
    end else begin
      state_q <= state_d;
    end
  end

  // Samples taken so far in the current window
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      win_cnt_q <= '0;
    end else if (win_end) begin
      win_cnt_q <= '0;
    end else if (take) begin
      win_cnt_q <= win_cnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // Per-axis trapezoidal integration
  // ****************************************************************
  // Gyro channels arrive pre-scaled so full scale of the fitted model
  // variant (360, 720 or 2160 degrees) maps to the 32-bit range.
  for (genvar ch = 0; ch < NUM_AXES; ch++) begin : g_axis
    logic signed [SAMPLE_W-1:0] cur;

    assign cur = buf_rd_data[ch*SAMPLE_W +: SAMPLE_W];

    // Previous sample carries across window boundaries
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        prev_q[ch] <= '0;
      end else if (take) begin
        prev_q[ch] <= cur;
      end
    end

    // Sum of current plus previous over the window
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        acc_q[ch] <= '0;
      end else if (state_q == ST_SCALE) begin
        acc_q[ch] <= '0;
      end else if (take) begin
        acc_q[ch] <= acc_q[ch] + ACC_W'(cur) + ACC_W'(prev_q[ch]);
      end
    end

    // Multiply by 1 / (2 * fs), nominal fs of 2000 SPS
    assign prod[ch]   = PROD_W'(acc_q[ch]) * $signed(PROD_W'({1'b0, RECIP}));
    assign scaled[ch] = prod[ch] >>> RECIP_SHIFT;

    // Clamp to the signed 32-bit range
    always_comb begin
      if (scaled[ch] > $signed(PROD_W'(DELTA_POS_MAX))) begin
        sat[ch] = DELTA_POS_MAX;
      end else if (scaled[ch] < -$signed(PROD_W'(DELTA_NEG_MAX))) begin
        sat[ch] = DELTA_NEG_MAX;
      end else begin
        sat[ch] = scaled[ch][DELTA_W-1:0];
      end
    end

    // Result register, loaded for all axes in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        delta_q[ch] <= {WORD_RESET, WORD_RESET};
      end else if (state_q == ST_SCALE) begin
        delta_q[ch] <= sat[ch];
      end
    end
  end

  // Update strobe, raised on the same edge that loads the results
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      avail_q <= 1'b0;
    end else begin
      avail_q <= (state_q == ST_SCALE);
    end
  end

  assign o_sample_available = avail_q;

  // ****************************************************************
  // Register readout
  // ****************************************************************
  // Word decode; either byte address of a word selects it. High words
  // are the upper half of the clamped 32-bit value, so 16-bit reads
  // also saturate at 7fff and 8000. The host may rescale by its own
  // measured sample rate; the device always uses the nominal rate.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= WORD_RESET;
    end else if (i_reg_rd) begin
      case ({i_reg_addr[ADDR_W-1:1], 1'b0})
        ADDR_Y_ANGLE_DELTA_LOW:  rdata_q <= delta_q[CH_ANGLE_Y][WORD_W-1:0];
        ADDR_Y_ANGLE_DELTA_HIGH: rdata_q <= delta_q[CH_ANGLE_Y][DELTA_W-1:WORD_W];
        ADDR_Z_ANGLE_DELTA_LOW:  rdata_q <= delta_q[CH_ANGLE_Z][WORD_W-1:0];
        ADDR_Z_ANGLE_DELTA_HIGH: rdata_q <= delta_q[CH_ANGLE_Z][DELTA_W-1:WORD_W];
        ADDR_X_VEL_DELTA_LOW:    rdata_q <= delta_q[CH_VEL_X][WORD_W-1:0];
        ADDR_X_VEL_DELTA_HIGH:   rdata_q <= delta_q[CH_VEL_X][DELTA_W-1:WORD_W];
        ADDR_Y_VEL_DELTA_LOW:    rdata_q <= delta_q[CH_VEL_Y][WORD_W-1:0];
        ADDR_Y_VEL_DELTA_HIGH:   rdata_q <= delta_q[CH_VEL_Y][DELTA_W-1:WORD_W];
        default:                 rdata_q <= WORD_UNMAPPED;
      endcase
    end
  end

  // Read answer strobe
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg_rd;
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;

endmodule

`default_nettype wire

// File: hw/delta_pkg.sv
// Constants shared by the delta angle and delta velocity output logic.
// Assumes byte addressing on the register read port, 16-bit words.

package delta_pkg;

  // ****************************************************************
  // Register map, byte addresses of the low byte of each word
  // ****************************************************************
  localparam int          ADDR_W                   = 7;
  localparam logic [6:0]  ADDR_Y_ANGLE_DELTA_LOW   = 7'h28;
  localparam logic [6:0]  ADDR_Y_ANGLE_DELTA_HIGH  = 7'h2a;
  localparam logic [6:0]  ADDR_Z_ANGLE_DELTA_LOW   = 7'h2c;
  localparam logic [6:0]  ADDR_Z_ANGLE_DELTA_HIGH  = 7'h2e;
  localparam logic [6:0]  ADDR_X_VEL_DELTA_LOW     = 7'h30;
  localparam logic [6:0]  ADDR_X_VEL_DELTA_HIGH    = 7'h32;
  localparam logic [6:0]  ADDR_Y_VEL_DELTA_LOW     = 7'h34;
  localparam logic [6:0]  ADDR_Y_VEL_DELTA_HIGH    = 7'h36;

  // ****************************************************************
  // Data formats
  // ****************************************************************
  localparam int           WORD_W        = 16;
  localparam int           DELTA_W       = 32;
  localparam int           SAMPLE_W      = 32;
  localparam int           ACC_W         = 50; // 65536 full-scale pairs need 49 bits
  localparam int           NUM_AXES      = 4;
  localparam int           DEC_W         = 16;
  localparam logic [15:0]  WORD_RESET    = 16'h0000;
  localparam logic [15:0]  WORD_UNMAPPED = 16'h0000;
  localparam logic [31:0]  DELTA_POS_MAX = 32'h7fffffff;
  localparam logic [31:0]  DELTA_NEG_MAX = 32'h80000000;

  // Channel order inside the sample word and the delta array
  localparam int CH_ANGLE_Y = 0;
  localparam int CH_ANGLE_Z = 1;
  localparam int CH_VEL_X   = 2;
  localparam int CH_VEL_Y   = 3;

  // ****************************************************************
  // Integration scaling
  // ****************************************************************
  localparam int NOMINAL_RATE_SPS = 2000;
  localparam int RECIP_SHIFT      = 32;
  localparam int RECIP_W          = 24;

  // Window control states
  typedef enum logic {
    ST_ACCUM,
    ST_SCALE
  } win_state_e;

endpackage

// File: hw/sample_buffer.sv
// Two-entry valid/ready buffer for the packed sensor sample word.
// Assumes both sides on the same clock; full and empty are exact.

`timescale 1ns/1ps
`default_nettype none

module sample_buffer #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 2
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_wr_valid,
  output logic                   o_wr_ready,
  input  wire logic [WIDTH-1:0]  i_wr_data,
  output logic                   o_rd_valid,
  input  wire logic              i_rd_ready,
  output logic      [WIDTH-1:0]  o_rd_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             push;
  logic             pop;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  assign o_wr_ready = (count_q != CNT_W'(DEPTH));
  assign o_rd_valid = (count_q != '0);
  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready;
  assign o_rd_data  = mem_q[rd_ptr_q];

  // Storage, written only on an accepted word
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (push) begin
      mem_q[wr_ptr_q] <= i_wr_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + PTR_W'(1);
      end
      if (push && !pop) begin
        count_q <= count_q + CNT_W'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CNT_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// File: test/delta_outputs_monitor.sv
// Port checks for the delta output block.
// Assumes binding to delta_outputs, single clock domain.
`timescale 1ns/1ps
`default_nettype none
module delta_outputs_monitor (
  input wire logic                  i_sys_clk,
  input wire logic                  i_rstn,
  input wire logic                  i_smp_valid,
  input wire logic                  o_smp_ready,
  input wire logic                  i_reg_rd,
  input wire logic [delta_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [delta_pkg::WORD_W-1:0] o_reg_rdata,
  input wire logic                  o_reg_rvalid,
  input wire logic                  o_sample_available
);
  import delta_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // ****
  // Read port and sample stream
  // ****
  property p_read_answer; i_reg_rd |=> o_reg_rvalid; endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_no_stray; o_reg_rvalid |-> $past(i_reg_rd); endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray read valid");
  property p_unmapped;
    i_reg_rd && (i_reg_addr[6:1] < 6'h14 || i_reg_addr[6:1] > 6'h1b) |=> o_reg_rdata == WORD_UNMAPPED;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rdata_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_pulse; o_sample_available |=> !o_sample_available; endproperty
  a_pulse: assert property (p_pulse) else $error("update pulse too long");
  property p_drain; !o_smp_ready |-> ##[1:3] o_smp_ready; endproperty
  a_drain: assert property (p_drain) else $error("buffer stuck full");
  property p_fill; $fell(o_smp_ready) |-> $past(i_smp_valid); endproperty
  a_fill: assert property (p_fill) else $error("full without a push");
  property p_reset; $rose(i_rstn) |-> o_smp_ready && !o_reg_rvalid && !o_sample_available; endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
endmodule
bind delta_outputs delta_outputs_monitor u_monitor (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_sample_available(o_sample_available));
`default_nettype wire

// File: test/host_reader.sv
// Host model reading registers through the read port.
// Assumes the bench drives on falling edges of the same clock.
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input  wire logic                         i_sys_clk,
  input  wire logic [delta_pkg::WORD_W-1:0] i_reg_rdata,
  input  wire logic                         i_reg_rvalid,
  output logic                              o_reg_rd,
  output logic      [delta_pkg::ADDR_W-1:0] o_reg_addr
);
  import delta_pkg::*;
  // Idle request at time zero
  initial begin
    o_reg_rd = 1'b0;
    o_reg_addr = '0;
  end
  // One read, answer awaited a bounded time
  task automatic read_word(input logic [ADDR_W-1:0] addr, output logic [WORD_W-1:0] data);
    int n;
    @(negedge i_sys_clk);
    o_reg_rd = 1'b1;
    o_reg_addr = addr;
    @(negedge i_sys_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~addr; // No stale address
    n = 0;
    while (i_reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge i_sys_clk);
      n++;
    end
    data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 'x;
  endtask
endmodule
`default_nettype wire

// File: test/test_delta_outputs.sv
// Self-checking bench for the delta output block.
// Assumes the host model and bound monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_delta_outputs;
  import delta_pkg::*;
  localparam longint RECIP = ((longint'(1) <<< 32) + NOMINAL_RATE_SPS) / (2 * NOMINAL_RATE_SPS);
  logic                        i_sys_clk;
  logic                        i_rstn;
  logic                        i_smp_valid = 1'b0;
  logic                        o_smp_ready;
  logic signed [SAMPLE_W-1:0]  smp [4] = '{default: '0};
  logic        [DEC_W-1:0]     dec = '0;
  logic                        reg_rd;
  logic        [ADDR_W-1:0]    reg_addr;
  logic        [WORD_W-1:0]    reg_rdata;
  logic                        reg_rvalid;
  logic                        sample_available;
  longint                      prev_m [4] = '{default: 0};
  longint                      acc_m [4] = '{default: 0};
  logic        [DELTA_W-1:0]   last_m [4] = '{default: '0};
  int                          cnt_m = 0, wins = 0, pulses = 0, failures = 0, checks_done = 0;
  logic                        refused = 1'b0;

  delta_outputs #(.SAMPLE_RATE_SPS(NOMINAL_RATE_SPS)) dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_smp_valid(i_smp_valid), .o_smp_ready(o_smp_ready), .i_gyro_y(smp[0]), .i_gyro_z(smp[1]),
    .i_accl_x(smp[2]), .i_accl_y(smp[3]), .i_decimation_setting(dec), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid),
    .o_sample_available(sample_available));
  host_reader host (.i_sys_clk(i_sys_clk), .i_reg_rdata(reg_rdata), .i_reg_rvalid(reg_rvalid),
    .o_reg_rd(reg_rd), .o_reg_addr(reg_addr));

  // ****
  // Helpers
  // ****
  always @(posedge i_sys_clk) if (sample_available === 1'b1) pulses <= pulses + 1;
  function automatic logic [31:0] scale(input longint s);
    logic signed [95:0] p;
    p = (96'(s) * RECIP) >>> 32;
    if (p > 96'sd2147483647) return DELTA_POS_MAX;
    if (p < -96'sd2147483648) return DELTA_NEG_MAX;
    return p[31:0];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Offer one sample set and track the expected window result
  task automatic push(input int gy, input int gz, input int ax, input int ay);
    int v[4];
    int n;
    v = '{gy, gz, ax, ay};
    @(negedge i_sys_clk);
    for (int i = 0; i < 4; i++) begin
      smp[i] = v[i];
      acc_m[i] += longint'(v[i]) + prev_m[i];
      prev_m[i] = v[i];
    end
    i_smp_valid = 1'b1;
    cnt_m++;
    if (cnt_m == int'(dec) + 1) begin
      for (int i = 0; i < 4; i++) begin
        last_m[i] = scale(acc_m[i]);
        acc_m[i] = 0;
      end
      cnt_m = 0;
      wins++;
    end
    n = 0;
    while (o_smp_ready !== 1'b1 && n < 50) begin
      refused = 1'b1;
      @(negedge i_sys_clk);
      n++;
    end
    check(o_smp_ready, 1'b1);
  endtask
  task automatic verify;
    logic [WORD_W-1:0] d;
    for (int i = 0; i < 4; i++) begin
      host.read_word(7'(ADDR_Y_ANGLE_DELTA_LOW + 4 * i), d);
      check(d, last_m[i][15:0]);
      host.read_word(7'(ADDR_Y_ANGLE_DELTA_HIGH + 4 * i), d);
      check(d, last_m[i][31:16]);
    end
  endtask
  // Stop offering, wait for the pulses, read back all words
  task automatic settle;
    int n;
    @(negedge i_sys_clk);
    i_smp_valid = 1'b0;
    n = 0;
    while (pulses != wins && n < 100) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(pulses, wins);
    verify();
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    logic [WORD_W-1:0] d;
    verify();
    host.read_word(7'h38, d);
    check(d, WORD_UNMAPPED);
    host.read_word(7'h26, d);
    check(d, WORD_UNMAPPED);
    $display("test reset done");
  endtask
  task automatic t_single;
    dec = 16'h0000;
    push(1000000, -1000000, 123456789, -7);
    settle();
    $display("test single done");
  endtask
  task automatic t_stream;
    int p0;
    refused = 1'b0;
    p0 = pulses;
    for (int k = 1; k < 7; k++) push(k * 50000000, -k * 3, 7777 * k, -k * 40000000);
    settle();
    check(refused, 1'b1);
    check(32'(pulses - p0), 32'd6);
    $display("test stream done");
  endtask
  task automatic t_window;
    dec = 16'h0003;
    for (int k = 0; k < 4; k++) push(k * 999, -k * 12345678, 300000000, k - 5);
    settle();
    $display("test window done");
  endtask
  task automatic t_saturate;
    dec = 16'h07ff;
    repeat (2048) push(32'h7fffffff, 32'h80000000, 32'h80000000, 32'h7fffffff);
    settle();
    $display("test saturate done");
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    i_rstn = 1'b0;
    repeat (5) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    t_reset();
    t_single();
    t_stream();
    t_window();
    t_saturate();
    stop_test();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
